/* File: src/afe_cfg_defs.vh */
`ifndef AFE_CFG_DEFS_VH
`define AFE_CFG_DEFS_VH

////////////////////////////////////////////////////////////////////////////////
// register addresses (4-bit serial address field)
`define ADDR_GAIN_RED       4'h0
`define ADDR_GAIN_GREEN     4'h1
`define ADDR_GAIN_BLUE      4'h2
`define ADDR_OFFSET_RED     4'h3
`define ADDR_OFFSET_GREEN   4'h4
`define ADDR_OFFSET_BLUE    4'h5
`define ADDR_MODE_FIRST     4'h6
`define ADDR_RESET_CTRL     4'hF

////////////////////////////////////////////////////////////////////////////////
// gain register fields
`define GAIN_CODE_MSB       9
`define GAIN_CODE_LSB       1
`define GAIN_RESET          9'h000

// offset register fields
`define COARSE_MSB          9
`define COARSE_LSB          8
`define FINE_MSB            7
`define FINE_LSB            0
`define OFFSET_RESET        10'h000

// first mode register fields
`define MUX_SEL_MSB         9
`define MUX_SEL_LSB         7
`define GAIN_SPAN_BIT       6
`define LINE_CLAMP_BIT      5
`define IMAGER_TYPE_BIT     4
`define NIBBLE_MODE_BIT     3
`define CLAMP_REF_MSB       2
`define CLAMP_REF_LSB       0
`define MODE_FIRST_RESET    10'h00E

// reset/control register
`define SOFT_RESET_BIT      9

////////////////////////////////////////////////////////////////////////////////
// channel mux codes
`define MUX_RGB             3'h0
`define MUX_RED             3'h1
`define MUX_GREEN           3'h2
`define MUX_BLUE            3'h3
`define MUX_RG              3'h4
`define MUX_GR              3'h5
`define MUX_GB              3'h6
`define MUX_BR              3'h7

// channel indices
`define CH_RED              2'h0
`define CH_GREEN            2'h1
`define CH_BLUE             2'h2

// clamp/reference codes and levels in mV
`define REF_HIGH_Z          3'h0
`define REF_SUPPLY          3'h7
`define REF_MV_0V           12'h000
`define REF_MV_1V25         12'h4E2
`define REF_MV_2V0          12'h7D0
`define REF_MV_2V6          12'hA28
`define REF_MV_2V8          12'hAF0
`define REF_MV_3V0          12'hBB8

// serial frame: 4 address bits then 10 data bits, msb first
`define FRAME_BITS          4'hE
`define DATA_BITS           10

`endif

/* File: src/serial_word_receiver.v */
`timescale 1ns/100ps
`include "afe_cfg_defs.vh"

module serial_word_receiver (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        serial_clock,
  input  wire        serial_data,
  input  wire        serial_load_n,
  output reg         word_valid,
  output reg  [3:0]  word_addr,
  output reg  [9:0]  word_data,
  output reg         frame_error
);

  reg        sclk_prev_reg;
  reg        load_n_prev_reg;
  reg [13:0] shift_reg;
  reg [3:0]  count_reg;

  wire sclk_rise = serial_clock & ~sclk_prev_reg;
  wire load_rise = serial_load_n & ~load_n_prev_reg;
  wire load_fall = ~serial_load_n & load_n_prev_reg;

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (!reset_n) begin
      sclk_prev_reg   <= 1'b0;
      load_n_prev_reg <= 1'b1;
      shift_reg       <= 14'h0000;
      count_reg       <= 4'h0;
      word_valid      <= 1'b0;
      word_addr       <= 4'h0;
      word_data       <= 10'h000;
      frame_error     <= 1'b0;
    end else begin
      sclk_prev_reg   <= serial_clock;
      load_n_prev_reg <= serial_load_n;
      word_valid      <= 1'b0;
      frame_error     <= 1'b0;
      if (load_fall) begin
        count_reg <= 4'h0;
      end else if (!serial_load_n && sclk_rise) begin
        shift_reg <= {shift_reg[12:0], serial_data};
        // saturate so over-long frames stay detectable
        if (count_reg != 4'hF) begin
          count_reg <= count_reg + 4'h1;
        end
      end
      if (load_rise) begin
        if (count_reg == `FRAME_BITS) begin
          word_valid <= 1'b1;
          word_addr  <= shift_reg[13:10];
          word_data  <= shift_reg[9:0];
        end else begin
          frame_error <= 1'b1;
        end
      end
    end
  end

endmodule // serial_word_receiver

/* File: src/mode_field_decode.v */
`timescale 1ns/100ps
`include "afe_cfg_defs.vh"

module mode_field_decode (
  input  wire [2:0]  channel_mux_select,
  input  wire [2:0]  clamp_ref_select,
  output reg  [2:0]  channel_active,
  output reg  [1:0]  channel_count,
  output reg  [1:0]  first_channel,
  output reg  [1:0]  second_channel,
  output reg         ref_drive_enable,
  output reg         ref_is_supply,
  output reg  [11:0] ref_level_mv
);

  //////////////////////////////////////////////////////////////////////////////
  // mux mode: active channels and conversion order
  always @* begin
    channel_active = 3'b111;
    channel_count  = 2'h3;
    first_channel  = `CH_RED;
    second_channel = `CH_GREEN;
    case (channel_mux_select)
      `MUX_RGB: begin
        channel_active = 3'b111;
        channel_count  = 2'h3;
      end
      `MUX_RED: begin
        channel_active = 3'b001;
        channel_count  = 2'h1;
        first_channel  = `CH_RED;
        second_channel = `CH_RED;
      end
      `MUX_GREEN: begin
        channel_active = 3'b010;
        channel_count  = 2'h1;
        first_channel  = `CH_GREEN;
        second_channel = `CH_GREEN;
      end
      `MUX_BLUE: begin
        channel_active = 3'b100;
        channel_count  = 2'h1;
        first_channel  = `CH_BLUE;
        second_channel = `CH_BLUE;
      end
      `MUX_RG: begin
        channel_active = 3'b011;
        channel_count  = 2'h2;
        first_channel  = `CH_RED;
        second_channel = `CH_GREEN;
      end
      `MUX_GR: begin
        channel_active = 3'b011;
        channel_count  = 2'h2;
        first_channel  = `CH_GREEN;
        second_channel = `CH_RED;
      end
      `MUX_GB: begin
        channel_active = 3'b110;
        channel_count  = 2'h2;
        first_channel  = `CH_GREEN;
        second_channel = `CH_BLUE;
      end
      default: begin
        channel_active = 3'b101;
        channel_count  = 2'h2;
        first_channel  = `CH_BLUE;
        second_channel = `CH_RED;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // clamp/reference level
  always @* begin
    ref_drive_enable = 1'b1;
    ref_is_supply    = 1'b0;
    ref_level_mv     = `REF_MV_0V;
    case (clamp_ref_select)
      `REF_HIGH_Z: ref_drive_enable = 1'b0;
      3'h1:        ref_level_mv     = `REF_MV_0V;
      3'h2:        ref_level_mv     = `REF_MV_1V25;
      3'h3:        ref_level_mv     = `REF_MV_2V0;
      3'h4:        ref_level_mv     = `REF_MV_2V6;
      3'h5:        ref_level_mv     = `REF_MV_2V8;
      3'h6:        ref_level_mv     = `REF_MV_3V0;
      default:     ref_is_supply    = 1'b1;
    endcase
  end

endmodule // mode_field_decode

/* File: src/afe_gain_offset_mode_config.v */
// Function
// - gain span bit picks 1x-5x when zero, 1.5x-7.5x when one.
// - gain registers use bits 9:1 as binary code; bit 0 ignored.
// - three independent offset registers, one per colour channel.
// - offset bits 9:8 are coarse code, -100 to +200 mV in 100 mV.
// - offset bits 7:0 are fine code, -180 to +180 mV in 1.4 mV.
// - positive offset codes correct in the usual imager offset direction.
// - three-bit mux select chooses one of eight channel modes.
// - line clamp enable gates clamping with line clamp strobe; off at reset.
// - imager type bit selects CCD when zero (default), CIS when one.
// - output width bit: zero 8-bit, one 4-bit; defaults to 4-bit.
// - clamp/reference code sets common reference voltage; 3.0 V default.
// - high-Z clamp/reference code stops driving the common reference input.
`timescale 1ns/100ps
`include "afe_cfg_defs.vh"

module afe_gain_offset_mode_config #(
  parameter GAIN_BITS   = 9,
  parameter COARSE_BITS = 2,
  parameter FINE_BITS   = 8
) (
  input  wire                   clk,
  input  wire                   reset_n,
  input  wire                   serial_clock,
  input  wire                   serial_data,
  input  wire                   serial_load_n,
  input  wire                   line_clamp_strobe,
  output wire [GAIN_BITS-1:0]   gain_code_red,
  output wire [GAIN_BITS-1:0]   gain_code_green,
  output wire [GAIN_BITS-1:0]   gain_code_blue,
  output wire [COARSE_BITS-1:0] coarse_offset_code_red,
  output wire [COARSE_BITS-1:0] coarse_offset_code_green,
  output wire [COARSE_BITS-1:0] coarse_offset_code_blue,
  output wire [FINE_BITS-1:0]   fine_offset_code_red,
  output wire [FINE_BITS-1:0]   fine_offset_code_green,
  output wire [FINE_BITS-1:0]   fine_offset_code_blue,
  output wire [2:0]             channel_mux_select,
  output wire                   gain_span_select,
  output wire                   line_clamp_gate_enable,
  output wire                   imager_type_select,
  output wire                   nibble_output_mode,
  output wire [2:0]             clamp_ref_select,
  output reg  [2:0]             channel_active,
  output reg  [1:0]             channel_count,
  output reg  [1:0]             first_channel,
  output reg  [1:0]             second_channel,
  output reg                    line_clamp_active,
  output reg                    common_ref_drive_enable,
  output reg                    common_ref_is_supply,
  output reg  [11:0]            common_ref_level_mv,
  output reg  [3:0]             output_bus_width,
  output reg                    write_accepted,
  output reg                    write_rejected
);

  localparam OFFSET_BITS = COARSE_BITS + FINE_BITS;

  ////////////////////////////////////////////////////////////////////////////
  // serial port front end

  wire        word_valid;
  wire [3:0]  word_addr;
  wire [9:0]  word_data;
  wire        frame_error;

  serial_word_receiver u_rx (
    .clk           (clk),
    .reset_n       (reset_n),
    .serial_clock  (serial_clock),
    .serial_data   (serial_data),
    .serial_load_n (serial_load_n),
    .word_valid    (word_valid),
    .word_addr     (word_addr),
    .word_data     (word_data),
    .frame_error   (frame_error)
  );

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  wire soft_reset = word_valid && (word_addr == `ADDR_RESET_CTRL) &&
                    word_data[`SOFT_RESET_BIT];
  wire mode_write = word_valid && (word_addr == `ADDR_MODE_FIRST);
  wire mapped     = (word_addr <= `ADDR_MODE_FIRST) ||
                    (word_addr == `ADDR_RESET_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // per-channel gain and offset storage

  reg  [GAIN_BITS-1:0]   gain_reg   [0:2];
  reg  [OFFSET_BITS-1:0] offset_reg [0:2];

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch = ch + 1) begin : g_chan
      wire [3:0] gain_addr   = `ADDR_GAIN_RED + ch[3:0];
      wire [3:0] offset_addr = `ADDR_OFFSET_RED + ch[3:0];

      always @(posedge clk) begin
        if (!reset_n || soft_reset) begin
          gain_reg[ch]   <= `GAIN_RESET;
          offset_reg[ch] <= `OFFSET_RESET;
        end else begin
          // only the addressed channel changes
          if (word_valid && word_addr == gain_addr) begin
            gain_reg[ch] <= word_data[`GAIN_CODE_MSB:`GAIN_CODE_LSB];
          end
          if (word_valid && word_addr == offset_addr) begin
            offset_reg[ch] <= word_data;
          end
        end
      end
    end
  endgenerate

  // straight binary gain code; span chosen by the mode field
  assign gain_code_red   = gain_reg[0];
  assign gain_code_green = gain_reg[1];
  assign gain_code_blue  = gain_reg[2];

  // coarse code in the top two bits
  assign coarse_offset_code_red   = offset_reg[0][`COARSE_MSB:`COARSE_LSB];
  assign coarse_offset_code_green = offset_reg[1][`COARSE_MSB:`COARSE_LSB];
  assign coarse_offset_code_blue  = offset_reg[2][`COARSE_MSB:`COARSE_LSB];

  // fine code passed unaltered; positive sign means usual imager direction
  assign fine_offset_code_red   = offset_reg[0][`FINE_MSB:`FINE_LSB];
  assign fine_offset_code_green = offset_reg[1][`FINE_MSB:`FINE_LSB];
  assign fine_offset_code_blue  = offset_reg[2][`FINE_MSB:`FINE_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // first mode register

  reg [9:0] mode_reg;

  always @(posedge clk) begin
    if (!reset_n || soft_reset) begin
      mode_reg <= `MODE_FIRST_RESET;
    end else if (mode_write) begin
      mode_reg <= word_data;
    end
  end

  assign channel_mux_select     = mode_reg[`MUX_SEL_MSB:`MUX_SEL_LSB];
  assign gain_span_select       = mode_reg[`GAIN_SPAN_BIT];
  assign line_clamp_gate_enable = mode_reg[`LINE_CLAMP_BIT];
  assign imager_type_select     = mode_reg[`IMAGER_TYPE_BIT];
  assign nibble_output_mode     = mode_reg[`NIBBLE_MODE_BIT];
  assign clamp_ref_select       = mode_reg[`CLAMP_REF_MSB:`CLAMP_REF_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // decoded mode controls

  wire [2:0]  dec_active;
  wire [1:0]  dec_count;
  wire [1:0]  dec_first;
  wire [1:0]  dec_second;
  wire        dec_drive;
  wire        dec_supply;
  wire [11:0] dec_level;

  mode_field_decode u_dec (
    .channel_mux_select (mode_reg[`MUX_SEL_MSB:`MUX_SEL_LSB]),
    .clamp_ref_select   (mode_reg[`CLAMP_REF_MSB:`CLAMP_REF_LSB]),
    .channel_active     (dec_active),
    .channel_count      (dec_count),
    .first_channel      (dec_first),
    .second_channel     (dec_second),
    .ref_drive_enable   (dec_drive),
    .ref_is_supply      (dec_supply),
    .ref_level_mv       (dec_level)
  );

  always @(posedge clk) begin
    if (!reset_n) begin
      channel_active          <= 3'b111;
      channel_count           <= 2'h3;
      first_channel           <= `CH_RED;
      second_channel          <= `CH_GREEN;
      line_clamp_active       <= 1'b0;
      common_ref_drive_enable <= 1'b1;
      common_ref_is_supply    <= 1'b0;
      common_ref_level_mv     <= `REF_MV_3V0;
      output_bus_width        <= 4'h4;
    end else begin
      channel_active          <= dec_active;
      channel_count           <= dec_count;
      first_channel           <= dec_first;
      second_channel          <= dec_second;
      // clamp only when enabled and the strobe is asserted
      line_clamp_active       <= mode_reg[`LINE_CLAMP_BIT] & line_clamp_strobe;
      common_ref_drive_enable <= dec_drive;
      common_ref_is_supply    <= dec_supply;
      common_ref_level_mv     <= dec_level;
      output_bus_width        <= mode_reg[`NIBBLE_MODE_BIT] ? 4'h4 : 4'h8;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write status pulses

  always @(posedge clk) begin
    if (!reset_n) begin
      write_accepted <= 1'b0;
      write_rejected <= 1'b0;
    end else begin
      write_accepted <= word_valid && mapped;
      // unmapped address or malformed frame
      write_rejected <= frame_error || (word_valid && !mapped);
    end
  end

endmodule // afe_gain_offset_mode_config

/* File: verif/afe_cfg_checker.sv */
`timescale 1ns/100ps
module afe_cfg_checker #(
  parameter GAIN_BITS   = 9,
  parameter COARSE_BITS = 2,
  parameter FINE_BITS   = 8
) (
  input wire                   clk,
  input wire                   reset_n,
  input wire                   line_clamp_strobe,
  input wire [GAIN_BITS-1:0]   gain_code_red,
  input wire [COARSE_BITS-1:0] coarse_offset_code_red,
  input wire [FINE_BITS-1:0]   fine_offset_code_red,
  input wire [2:0]             channel_mux_select,
  input wire                   line_clamp_gate_enable,
  input wire                   nibble_output_mode,
  input wire [2:0]             clamp_ref_select,
  input wire [1:0]             channel_count,
  input wire                   line_clamp_active,
  input wire                   common_ref_drive_enable,
  input wire                   common_ref_is_supply,
  input wire [11:0]            common_ref_level_mv,
  input wire [3:0]             output_bus_width,
  input wire                   write_accepted,
  input wire                   write_rejected
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  a_clamp_gate: assert property (
    line_clamp_active == $past(line_clamp_gate_enable && line_clamp_strobe))
    else $error("line clamp gating wrong");
  a_ref_release: assert property (
    $changed(clamp_ref_select) |=> common_ref_drive_enable == ($past(clamp_ref_select) != 3'h0))
    else $error("reference drive enable wrong");
  a_ref_supply: assert property (
    common_ref_is_supply == ($past(clamp_ref_select) == 3'h7))
    else $error("supply reference flag wrong");
  a_ref_level: assert property (
    ($past(clamp_ref_select) == 3'h6) |-> common_ref_level_mv == 12'h0BB8)
    else $error("reference level wrong");
  a_width_sel: assert property (
    $changed(nibble_output_mode) |=> output_bus_width == (nibble_output_mode ? 4'h4 : 4'h8))
    else $error("output width wrong");
  a_mux_count: assert property (
    channel_count == (($past(channel_mux_select) == 3'h0) ? 2'h3 :
                      ($past(channel_mux_select) < 3'h4) ? 2'h1 : 2'h2))
    else $error("channel count wrong");
  a_field_hold: assert property (
    !$stable({gain_code_red, coarse_offset_code_red, fine_offset_code_red,
              channel_mux_select, clamp_ref_select}) |-> write_accepted || $past(write_accepted))
    else $error("field changed without a write");
  a_reject_quiet: assert property (
    write_rejected |-> ##1 $stable({gain_code_red, fine_offset_code_red,
                                    channel_mux_select, clamp_ref_select})[*2])
    else $error("refused frame changed a field");
endmodule // afe_cfg_checker

bind afe_gain_offset_mode_config afe_cfg_checker #(
  .GAIN_BITS(GAIN_BITS), .COARSE_BITS(COARSE_BITS), .FINE_BITS(FINE_BITS)
) afe_cfg_checker_inst (
  .clk, .reset_n, .line_clamp_strobe, .gain_code_red, .coarse_offset_code_red,
  .fine_offset_code_red, .channel_mux_select, .line_clamp_gate_enable,
  .nibble_output_mode, .clamp_ref_select, .channel_count, .line_clamp_active,
  .common_ref_drive_enable, .common_ref_is_supply, .common_ref_level_mv,
  .output_bus_width, .write_accepted, .write_rejected
);

/* File: verif/serial_host_model.sv */
`timescale 1ns/100ps
module serial_host_model (
  input  wire clk,
  output reg  serial_clock,
  output reg  serial_data,
  output reg  serial_load_n
);
  initial begin
    serial_clock  = 1'b0;
    serial_data   = 1'b0;
    serial_load_n = 1'b1;
  end
  // msb first from bit 13, nbits long; bit clock idles low between frames
  task send_frame(input [13:0] word, input integer nbits);
    integer i;
    begin
      @(posedge clk) serial_load_n <= 1'b0;
      for (i = 13; i > 13 - nbits; i = i - 1) begin
        serial_data <= word[i];
        repeat (2) @(posedge clk);
        serial_clock <= 1'b1;
        repeat (2) @(posedge clk);
        serial_clock <= 1'b0;
      end
      repeat (2) @(posedge clk);
      serial_load_n <= 1'b1;
      // released data line shows no stale value
      serial_data   <= ~serial_data;
    end
  endtask
endmodule // serial_host_model

/* File: verif/afe_gain_offset_mode_config_tb.sv */
`timescale 1ns/100ps
module afe_gain_offset_mode_config_tb;
  reg         clk;
  reg         reset_n = 1'b0;
  reg         strobe  = 1'b0;
  wire        sclk, sdata, sload_n;
  wire [8:0]  gain_r, gain_g, gain_b;
  wire [1:0]  co_r, co_g, co_b, ch_count, ch_first, ch_second;
  wire [7:0]  fo_r, fo_g, fo_b;
  wire [2:0]  mux_sel, ref_sel, ch_active;
  wire        span, clamp_en, imager, nibble, clamp_act, ref_drv, ref_sup, acc, rej;
  wire [11:0] ref_mv;
  wire [3:0]  bus_w;
  integer     error_cnt = 0;
  integer     check_count = 0;
  integer     i;
  reg  [9:0]  m;
  localparam [23:0] act_tab = 24'hB9_B88F;
  localparam [7:0]  fst_tab = 8'h94;
  localparam [7:0]  snd_tab = 8'h21;
  localparam [71:0] lvl_tab = 72'hBB8_AF0_A28_7D0_4E2_000;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  serial_host_model serial_host_model_inst (.clk(clk), .serial_clock(sclk),
    .serial_data(sdata), .serial_load_n(sload_n));

  afe_gain_offset_mode_config afe_gain_offset_mode_config_inst (
    .clk(clk), .reset_n(reset_n), .serial_clock(sclk), .serial_data(sdata),
    .serial_load_n(sload_n), .line_clamp_strobe(strobe),
    .gain_code_red(gain_r), .gain_code_green(gain_g), .gain_code_blue(gain_b),
    .coarse_offset_code_red(co_r), .coarse_offset_code_green(co_g),
    .coarse_offset_code_blue(co_b), .fine_offset_code_red(fo_r),
    .fine_offset_code_green(fo_g), .fine_offset_code_blue(fo_b),
    .channel_mux_select(mux_sel), .gain_span_select(span),
    .line_clamp_gate_enable(clamp_en), .imager_type_select(imager),
    .nibble_output_mode(nibble), .clamp_ref_select(ref_sel),
    .channel_active(ch_active), .channel_count(ch_count), .first_channel(ch_first),
    .second_channel(ch_second), .line_clamp_active(clamp_act),
    .common_ref_drive_enable(ref_drv), .common_ref_is_supply(ref_sup),
    .common_ref_level_mv(ref_mv), .output_bus_width(bus_w),
    .write_accepted(acc), .write_rejected(rej));

  ////////////////////////////////////////////////////////////////////////////////
  task close_out;
    begin
      if (error_cnt == 0 && check_count > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask

  task chk(input string name, input [11:0] got, input [11:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("BAD %s expected %h seen %h", name, exp, got);
      end
    end
  endtask

  // one serial write, then wait for its verdict pulse and the decode to settle
  task frame(input [3:0] addr, input [9:0] data, input integer nbits, input ok);
    integer n;
    begin
      serial_host_model_inst.send_frame({addr, data}, nbits);
      n = 0;
      while (acc !== 1'b1 && rej !== 1'b1 && n < 10) begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      chk("accepted", {11'h000, acc}, {11'h000, ok});
      chk("rejected", {11'h000, rej}, {11'h000, ~ok});
      repeat (3) @(posedge clk);
      #1;
    end
  endtask

  task chk_defaults;
    begin
      chk("gain_r", gain_r, 12'h000);
      chk("fine_r", fo_r, 12'h000);
      chk("mux", mux_sel, 12'h000);
      chk("span", span, 12'h000);
      chk("clamp_en", clamp_en, 12'h000);
      chk("imager", imager, 12'h000);
      chk("nibble", nibble, 12'h001);
      chk("width", bus_w, 12'h004);
      chk("ref", ref_sel, 12'h006);
      chk("level", ref_mv, 12'hBB8);
      chk("clamp_act", clamp_act, 12'h000);
    end
  endtask

  initial begin
    #200000;
    error_cnt = error_cnt + 1;
    close_out;
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    chk_defaults;
    frame(4'h0, 10'h3FF, 14, 1'b1);
    chk("gain_r", gain_r, 12'h1FF);
    frame(4'h1, 10'h001, 14, 1'b1);
    chk("gain_g", gain_g, 12'h000);
    frame(4'h2, 10'h2AA, 14, 1'b1);
    chk("gain_b", gain_b, 12'h155);
    chk("gain_r", gain_r, 12'h1FF);
    frame(4'h3, 10'h2C5, 14, 1'b1);
    frame(4'h4, 10'h17F, 14, 1'b1);
    frame(4'h5, 10'h380, 14, 1'b1);
    chk("co_r", co_r, 12'h002);
    chk("fo_r", fo_r, 12'h0C5);
    chk("co_g", co_g, 12'h001);
    chk("fo_g", fo_g, 12'h07F);
    chk("co_b", co_b, 12'h003);
    chk("fo_b", fo_b, 12'h080);
    @(posedge clk) strobe <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      // cis only with the 0 V, 1.25 V and high-Z references
      m = {i[2:0], i[0], i[1], i < 3, ~i[0], i[2:0]};
      frame(4'h6, m, 14, 1'b1);
      chk("mux", mux_sel, i[2:0]);
      chk("active", ch_active, act_tab[3*i +: 3]);
      chk("count", ch_count, (i == 0) ? 2'h3 : (i < 4) ? 2'h1 : 2'h2);
      if (i > 3) begin
        chk("first", ch_first, fst_tab[2*(i-4) +: 2]);
        chk("second", ch_second, snd_tab[2*(i-4) +: 2]);
      end else if (i == 0) begin
        chk("first", ch_first, 12'h000);
        chk("second", ch_second, 12'h001);
      end
      chk("span", span, i[0]);
      chk("clamp_act", clamp_act, i[1]);
      chk("imager", imager, i < 3);
      chk("width", bus_w, i[0] ? 12'h008 : 12'h004);
      chk("drive", ref_drv, i != 0);
      chk("supply", ref_sup, i == 7);
      if (i > 0 && i < 7) begin
        chk("level", ref_mv, lvl_tab[12*(i-1) +: 12]);
      end
    end
    @(posedge clk) strobe <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("clamp_act", clamp_act, 12'h000);
    frame(4'h6, 10'h000, 13, 1'b0);
    frame(4'h9, 10'h000, 14, 1'b0);
    // control word without the reset bit: taken, changes nothing
    frame(4'hF, 10'h1FF, 14, 1'b1);
    chk("mux", mux_sel, 12'h007);
    chk("gain_b", gain_b, 12'h155);
    frame(4'hF, 10'h200, 14, 1'b1);
    chk_defaults;
    frame(4'h3, 10'h1AB, 14, 1'b1);
    frame(4'h6, 10'h3C1, 14, 1'b1);
    @(posedge clk) reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    chk_defaults;
    close_out;
  end
endmodule // afe_gain_offset_mode_config_tb
